// ---- verilog/rx_realign_defines.svh ----
`ifndef RX_REALIGN_DEFINES_SVH
`define RX_REALIGN_DEFINES_SVH

// Synchroniser depth in words
`define SYNC_FIFO_DEPTH 4
// Allowed deserialisation factors
`define WORD_WIDTH_NARROW 8
`define WORD_WIDTH_WIDE 10
// Least request high time and least low time, in parallel-clock periods
`define ALIGN_HIGH_CYCLES 2
`define ALIGN_LOW_CYCLES 3
// Divider from the system clock to the parallel word rate
`define WORD_RATE_DIV 10
// Fill level at which reading starts, half the FIFO
`define SYNC_FIFO_PRIME 2
// Source clock multiplier giving the serial bit clock
`define BIT_CLOCK_MULT 10

`endif

// ---- verilog/rx_realign_pkg.sv ----
package rx_realign_pkg;

typedef enum logic [1:0] {
    ALIGN_IDLE = 2'b00,
    ALIGN_CHECK = 2'b01,
    ALIGN_PULSE = 2'b10,
    ALIGN_GAP = 2'b11
} align_state_e;

typedef logic [3:0] slip_count_t;

endpackage

// ---- verilog/rx_realign_if.sv ----
`timescale 1ns/1ps

interface rx_realign_if #(
    parameter int WORD_W = 10
);
    logic [WORD_W-1:0] word;
    logic word_valid;
    logic word_ready;
    logic align_req;
    logic word_tick;

    modport device (
        output word,
        output word_valid,
        input word_ready,
        input align_req,
        output word_tick
    );

    modport fabric (
        input word,
        input word_valid,
        output word_ready,
        output align_req,
        input word_tick
    );
endinterface

// ---- verilog/sync_fifo.sv ----
`timescale 1ns/1ps

module sync_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [$clog2(DEPTH):0] level_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic do_wr;
    logic do_rd;

    assign do_wr = in_valid_i && in_ready_o;
    assign do_rd = out_valid_o && out_ready_i;
    assign in_ready_o = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];
    assign level_o = count;

    always_ff @(posedge clock_i) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
            end
            count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule

// ---- verilog/rx_realign_device.sv ----
`timescale 1ns/1ps
`include "rx_realign_defines.svh"

// Overview of operation
// - Each channel owns its own word synchroniser
// - Synchroniser is a four-word FIFO, word-wide
// - Written at word rate, read on rd_tick of the same clock
// - Both clocks share one frequency exactly
// - No flags or enables offered to users; FIFO ready is still output on par_word_ready_o
// - Realign parallel words per channel, shared clock
// - Request comes from a pin or logic
// - Each request rising edge slips one bit
// - Realigner never bypassed, otherwise pure latency
// - User logic retries request until pattern matches
// - Word width selectable, 8 or 10
// - Output mixes two bit-slip registers by count
// - Past last position: later register, count zero
// - Valid word resumes on next word cycle
// - Request held high two word periods
// - Request held low three word periods between
// - Fabric registers incoming words before checking
// - Fabric registers request before the realigner
// - Bit clock is source clock times multiplier
module rx_realign_device
    import rx_realign_pkg::*;
#(
    parameter int WORD_W = `WORD_WIDTH_WIDE,
    parameter int DEPTH = `SYNC_FIFO_DEPTH,
    parameter int DIV = `WORD_RATE_DIV,
    parameter int MULT = `BIT_CLOCK_MULT
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic [WORD_W-1:0] par_word_i,
    input wire logic align_pin_i,
    input wire logic align_from_pin_i,
    output logic par_word_ready_o,
    output logic [7:0] bit_clock_mult_o,
    rx_realign_if.device fab
);
    localparam int LW = $clog2(DEPTH);

    // ----------------------------------------------------------------
    // Word-rate divider
    // ----------------------------------------------------------------
    logic [7:0] div_cnt;
    logic tick;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_cnt <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (div_cnt == 8'(DIV - 1));
            div_cnt <= (div_cnt == 8'(DIV - 1)) ? '0 : div_cnt + 8'h01;
        end
    end

    // Multiplier reported for the bit clock generator outside
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bit_clock_mult_o <= 8'h00;
        end else begin
            bit_clock_mult_o <= 8'(MULT);
        end
    end

    // ----------------------------------------------------------------
    // Channel synchroniser
    // ----------------------------------------------------------------
    // Frequency lock keeps the fill near half, so the flag on par_word_ready_o stays high.
    logic [WORD_W-1:0] sync_word;
    logic sync_valid;
    logic sync_in_ready;
    logic [LW:0] sync_level;
    logic primed;
    logic rd_tick;

    sync_fifo #(.WIDTH(WORD_W), .DEPTH(DEPTH)) u_sync (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .in_data_i(par_word_i),
        .in_valid_i(tick),
        .in_ready_o(sync_in_ready),
        .out_data_o(sync_word),
        .out_valid_o(sync_valid),
        .out_ready_i(rd_tick),
        .level_o(sync_level)
    );

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            primed <= 1'b0;
        end else if (sync_level >= (LW+1)'(`SYNC_FIFO_PRIME)) begin
            primed <= 1'b1;
        end
    end

    // Read on the shared clock phase, in the same tick as a write, two ticks after the word was written.
    // Stall from the fabric backs up the FIFO and reaches par_word_ready_o.
    assign rd_tick = tick && primed && sync_valid && (!fab.word_valid || fab.word_ready);

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            par_word_ready_o <= 1'b0;
        end else begin
            par_word_ready_o <= sync_in_ready;
        end
    end

    // ----------------------------------------------------------------
    // Request edge capture
    // ----------------------------------------------------------------
    logic req_in;
    logic req_q;
    logic req_armed;
    logic slip_req;

    assign req_in = align_from_pin_i ? align_pin_i : fab.align_req;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            req_q <= 1'b0;
            req_armed <= 1'b1;
        end else if (tick) begin
            req_q <= req_in;
            if (!req_q) begin
                req_armed <= 1'b1;
            end else if (req_armed) begin
                req_armed <= 1'b0;
            end
        end
    end

    assign slip_req = tick && req_q && req_armed;

    // ----------------------------------------------------------------
    // Bit-slip registers and slip counter
    // ----------------------------------------------------------------
    logic [WORD_W-1:0] slip_reg2;
    logic [WORD_W-1:0] slip_reg3;
    slip_count_t slip_cnt;
    logic hold_word;
    logic [2*WORD_W-1:0] joined;
    logic [WORD_W-1:0] aligned;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            slip_reg2 <= '0;
            slip_reg3 <= '0;
        end else if (rd_tick) begin
            slip_reg3 <= sync_word;
            slip_reg2 <= slip_reg3;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            slip_cnt <= '0;
            hold_word <= 1'b0;
        end else if (slip_req) begin
            if (slip_cnt == slip_count_t'(WORD_W - 1)) begin
                slip_cnt <= '0;
                hold_word <= 1'b1;
            end else begin
                slip_cnt <= slip_cnt + slip_count_t'(1);
            end
        end else if (rd_tick) begin
            hold_word <= 1'b0;
        end
    end

    assign joined = {slip_reg3, slip_reg2};
    assign aligned = joined[slip_cnt +: WORD_W];

    // ----------------------------------------------------------------
    // Output to the fabric
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fab.word <= '0;
            fab.word_valid <= 1'b0;
            fab.word_tick <= 1'b0;
        end else begin
            fab.word_tick <= tick;
            if (rd_tick && !hold_word) begin
                fab.word <= aligned;
                fab.word_valid <= 1'b1;
            end else if (fab.word_ready) begin
                fab.word_valid <= 1'b0;
            end
        end
    end

    initial begin
        if (WORD_W != `WORD_WIDTH_NARROW && WORD_W != `WORD_WIDTH_WIDE) begin
            $error("word width must be 8 or 10");
        end
    end
endmodule

// ---- verilog/rx_realign_fabric.sv ----
`timescale 1ns/1ps
`include "rx_realign_defines.svh"

module rx_realign_fabric
    import rx_realign_pkg::*;
#(
    parameter int WORD_W = `WORD_WIDTH_WIDE
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic enable_i,
    input wire logic [WORD_W-1:0] pattern_i,
    output logic locked_o,
    output logic [WORD_W-1:0] data_o,
    output logic data_valid_o,
    rx_realign_if.fabric dev
);
    align_state_e state;
    logic [WORD_W-1:0] in_word;
    logic in_valid;
    logic req_gen;
    logic [1:0] wait_cnt;

    assign dev.word_ready = 1'b1;

    // ----------------------------------------------------------------
    // Input stage
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            in_word <= '0;
            in_valid <= 1'b0;
        end else begin
            in_valid <= dev.word_valid;
            if (dev.word_valid) begin
                in_word <= dev.word;
            end
        end
    end

    // ----------------------------------------------------------------
    // Alignment search
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= ALIGN_IDLE;
            req_gen <= 1'b0;
            wait_cnt <= '0;
            locked_o <= 1'b0;
        end else begin
            unique case (state)
                ALIGN_IDLE: begin
                    if (enable_i) begin
                        state <= ALIGN_CHECK;
                    end
                end
                ALIGN_CHECK: begin
                    if (in_valid) begin
                        locked_o <= (in_word == pattern_i);
                        if (in_word != pattern_i) begin
                            state <= ALIGN_PULSE;
                            req_gen <= 1'b1;
                            wait_cnt <= '0;
                        end
                    end
                end
                ALIGN_PULSE: begin
                    if (dev.word_tick) begin
                        // One extra word period covers the output register
                        if (wait_cnt == 2'(`ALIGN_HIGH_CYCLES)) begin
                            req_gen <= 1'b0;
                            wait_cnt <= '0;
                            state <= ALIGN_GAP;
                        end else begin
                            wait_cnt <= wait_cnt + 2'b01;
                        end
                    end
                end
                ALIGN_GAP: begin
                    // Low time also lets the slipped word reach the checker
                    if (dev.word_tick) begin
                        if (wait_cnt == 2'(`ALIGN_LOW_CYCLES)) begin
                            state <= ALIGN_CHECK;
                        end else begin
                            wait_cnt <= wait_cnt + 2'b01;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dev.align_req <= 1'b0;
        end else if (dev.word_tick) begin
            dev.align_req <= req_gen;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            data_o <= '0;
            data_valid_o <= 1'b0;
        end else begin
            data_o <= in_word;
            data_valid_o <= in_valid;
        end
    end
endmodule

// ---- dv/rx_realign_assertions.sv ----
`timescale 1ns/1ps

module rx_realign_assertions #(
    parameter int WORD_W = 10,
    parameter int DIV = 10
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic [WORD_W-1:0] word,
    input wire logic word_valid,
    input wire logic word_ready,
    input wire logic align_req,
    input wire logic word_tick
);
    logic [7:0] gap;
    logic [7:0] hi_run;
    logic [7:0] lo_run;
    logic ticked;

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    // ------------------------------------------------------------
    // Run counters
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            gap <= 8'h00;
        end else if (word_tick) begin
            gap <= 8'h00;
        end else begin
            gap <= gap + 8'h01;
        end
    end

    // The first tick after reset follows the divider's start-up, not a full period
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ticked <= 1'b0;
        end else if (word_tick) begin
            ticked <= 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hi_run <= 8'h00;
        end else if (!align_req) begin
            hi_run <= 8'h00;
        end else if (hi_run != 8'hff) begin
            hi_run <= hi_run + 8'h01;
        end
    end

    // Starts saturated so the first request after reset is not flagged
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lo_run <= 8'hff;
        end else if (align_req) begin
            lo_run <= 8'h00;
        end else if (lo_run != 8'hff) begin
            lo_run <= lo_run + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_tick_period: assert property (word_tick && ticked |-> gap == 8'(DIV - 1))
        else $error("word tick spacing wrong");
    a_tick_not_late: assert property (gap < (ticked ? 8'(DIV) : 8'(DIV + 2)))
        else $error("word tick missing");
    a_word_with_valid: assert property ($changed(word) |-> word_valid)
        else $error("word changed without valid");
    a_valid_after_tick: assert property ($rose(word_valid) |-> word_tick)
        else $error("valid not raised with the word tick");
    a_valid_taken: assert property (word_valid && word_ready |=> !word_valid)
        else $error("valid held after acceptance");
    a_valid_steady: assert property (word_valid |-> ##[1:25] word_valid)
        else $error("word stream stalled");
    a_req_high_min: assert property ($fell(align_req) |-> hi_run >= 8'(2 * DIV))
        else $error("request pulse too short");
    a_req_low_min: assert property ($rose(align_req) |-> lo_run >= 8'(3 * DIV))
        else $error("request gap too short");
endmodule

// ---- dv/test_dpa_rx_sync_bitslip_realigner.sv ----
`timescale 1ns/1ps
`include "rx_realign_defines.svh"

module test_dpa_rx_sync_bitslip_realigner;
    localparam logic [9:0] P10 = 10'h0f3;
    localparam logic [7:0] P8 = 8'h1d;
    logic clock, rst_b, from_pin, align_pin, enable, lock10, lock8, vld10, vld8, ready10;
    logic prev10, prev8, ready8;
    logic [9:0] par10, pat10, dat10, last10;
    logic [7:0] par8, pat8, dat8, last8, mult10, mult8, rises10, rises8;
    int bad_count, num_checks, cyc;

    rx_realign_if bus ();
    rx_realign_if #(.WORD_W(8)) bus8 ();

    rx_realign_device i_rx_realign_device (.clock_i(clock), .rst_b_i(rst_b),
        .par_word_i(par10), .align_pin_i(align_pin), .align_from_pin_i(from_pin),
        .par_word_ready_o(ready10), .bit_clock_mult_o(mult10), .fab(bus.device));
    rx_realign_fabric i_rx_realign_fabric (.clock_i(clock), .rst_b_i(rst_b),
        .enable_i(enable), .pattern_i(pat10), .locked_o(lock10), .data_o(dat10),
        .data_valid_o(vld10), .dev(bus.fabric));
    rx_realign_device #(.WORD_W(8)) i_rx_realign_device_8 (.clock_i(clock), .rst_b_i(rst_b),
        .par_word_i(par8), .align_pin_i(align_pin), .align_from_pin_i(from_pin),
        .par_word_ready_o(ready8), .bit_clock_mult_o(mult8), .fab(bus8.device));
    rx_realign_fabric #(.WORD_W(8)) i_rx_realign_fabric_8 (.clock_i(clock), .rst_b_i(rst_b),
        .enable_i(enable), .pattern_i(pat8), .locked_o(lock8), .data_o(dat8),
        .data_valid_o(vld8), .dev(bus8.fabric));
    rx_realign_assertions #(.DIV(`WORD_RATE_DIV)) i_rx_realign_assertions (
        .clock_i(clock), .rst_b_i(rst_b), .word(bus.word), .word_valid(bus.word_valid),
        .word_ready(bus.word_ready), .align_req(bus.align_req), .word_tick(bus.word_tick));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // ------------------------------------------------------------
    // Monitors and timeout
    // ------------------------------------------------------------
    always @(posedge clock) begin
        prev10 <= bus.align_req;
        prev8 <= bus8.align_req;
        cyc <= cyc + 1;
        if (!rst_b) begin
            rises10 <= 8'h00;
            rises8 <= 8'h00;
            last10 <= 10'h000;
            last8 <= 8'h00;
        end else begin
            if (bus.align_req && !prev10) rises10 <= rises10 + 8'h01;
            if (bus8.align_req && !prev8) rises8 <= rises8 + 8'h01;
            if (vld10) last10 <= dat10;
            if (vld8) last8 <= dat8;
        end
        if (cyc == 20000) begin
            bad_count++;
            conclude();
        end
    end

    function automatic logic [9:0] rotr(logic [9:0] v, int c, int w);
        logic [9:0] r;
        r = 10'h000;
        for (int i = 0; i < w; i++) r[i] = v[(i + c) % w];
        return r;
    endfunction

    task automatic check_word(input logic [9:0] got, input logic [9:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic words(input int n);
        repeat (n * `WORD_RATE_DIV) @(posedge clock);
    endtask

    task automatic do_reset;
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (10) @(posedge clock);
        check_val(mult10, 8'h00);
        rst_b <= 1'b1;
    endtask

    // Pin requests keep the least high and low times
    task automatic pin_pulse(input int hi);
        @(posedge clock);
        align_pin <= 1'b1;
        words(hi);
        align_pin <= 1'b0;
        words(4);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_latency;
        do_reset;
        par10 <= 10'h2b5;
        words(1);
        check_val(mult10, 8'(`BIT_CLOCK_MULT));
        check_val(mult8, 8'(`BIT_CLOCK_MULT));
        words(8);
        check_word(last10, 10'h2b5);
        check_val(rises10, 8'h00);
        check_val({7'h00, ready10}, 8'h01);
        check_val({7'h00, ready8}, 8'h01);
    endtask

    task automatic t_lock;
        do_reset;
        pat10 <= P10;
        par10 <= rotr(P10, 7, 10);
        pat8 <= P8;
        par8 <= 8'(rotr({2'b00, P8}, 3, 8));
        enable <= 1'b1;
        for (int i = 0; i < 4000 && !(lock10 === 1'b1 && lock8 === 1'b1); i++) @(posedge clock);
        words(4);
        check_val({6'h00, lock10, lock8}, 8'h03);
        check_word(last10, P10);
        check_word({2'b00, last8}, {2'b00, P8});
        check_val(rises10, 8'h03);
        check_val(rises8, 8'h05);
    endtask

    task automatic t_pin;
        do_reset;
        par10 <= P10;
        enable <= 1'b0;
        from_pin <= 1'b1;
        words(6);
        pin_pulse(8);
        words(2);
        check_word(last10, rotr(P10, 1, 10));
        check_word({2'b00, last8}, rotr({2'b00, P8}, 4, 8));
        for (int i = 0; i < 9; i++) pin_pulse(3);
        words(2);
        check_word(last10, P10);
        check_word({2'b00, last8}, rotr({2'b00, P8}, 5, 8));
    endtask

    // One new word per word period, set mid-period so each write takes it.
    // Words leave in order five word periods later and the input never backs up.
    task automatic t_fifo;
        do_reset;
        repeat (5) @(posedge clock);
        for (int i = 0; i < 12; i++) begin
            par10 <= 10'h100 + 10'(i);
            repeat (5) @(posedge clock);
            check_val({7'h00, ready10}, 8'h01);
            if (i >= 5) check_word(last10, 10'h100 + 10'(i - 5));
            repeat (5) @(posedge clock);
        end
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        rst_b = 1'b0;
        from_pin = 1'b0;
        align_pin = 1'b0;
        enable = 1'b0;
        par10 = 10'h000;
        pat10 = 10'h000;
        par8 = 8'h00;
        pat8 = 8'h00;
        bad_count = 0;
        num_checks = 0;
        cyc = 0;
        t_latency;
        t_lock;
        t_pin;
        t_fifo;
        conclude;
    end
endmodule
